// ==== sim/fdr_link_monitor.sv ====
// Protocol checker for the double-rate read link
`timescale 1ns/1ps
module fdr_link_monitor (
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       ce_n,
    input wire logic       sck,
    input wire logic [3:0] host_io_oe_n,
    input wire logic [3:0] dev_io_o,
    input wire logic [3:0] dev_io_oe_n
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_dev_off;
        dev_io_oe_n == 4'hF;
    endsequence
    sequence s_sck_hold;
        $stable(sck) [*7];
    endsequence
    a_sck_half_period: assert property ($changed(sck) |=> s_sck_hold)
        else $error("serial clock half period too short");
    a_sck_idle_low: assert property (ce_n |-> !sck)
        else $error("serial clock not low while deselected");
    // Lanes move once per edge, so they must hold between edges
    a_data_lane_hold: assert property (($changed(dev_io_o) && dev_io_oe_n != 4'hF)
        |=> $stable(dev_io_o) [*6])
        else $error("flash data lanes changed between edges");
    a_ce_high_gap: assert property ($rose(ce_n) |=> ce_n [*4])
        else $error("chip enable high gap too short");
    a_dev_release: assert property ($rose(ce_n) |-> ##[1:6] s_dev_off)
        else $error("flash still drives after deselect");
    a_host_off_idle: assert property (ce_n |-> host_io_oe_n == 4'hF)
        else $error("host drives lanes while deselected");
    a_opcode_quiet: assert property ($fell(ce_n) |-> s_dev_off [*8])
        else $error("flash drives during command phase");
    a_no_contention: assert property ((~dev_io_oe_n & ~host_io_oe_n) == 4'h0)
        else $error("both ends drive one lane");
endmodule // fdr_link_monitor

// ==== sim/testbench.sv ====
// Self-checking bench joining host and flash ends of the read link
`timescale 1ns/1ps
module testbench;
    import fdr_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        start = 1'b0;
    logic        wr_busy = 1'b0;
    logic        quad_en = 1'b0;
    logic        qcm = 1'b0;
    logic        skip = 1'b0;
    fdr_kind_t   kind = FDR_K_SINGLE;
    logic [23:0] saddr = 24'h000000;
    logic [7:0]  mode = 8'h00;
    logic [4:0]  dum = 5'h00;
    logic [15:0] cnt = 16'h0001;
    logic [23:0] mem_addr;
    logic [7:0]  rd_data;
    logic        busy, rd_valid, done, err, crm, rej;
    int          err_count = 0;
    int          comparisons = 0;
    always #10 clk = ~clk;
    // Array content mixes top and bottom bytes so a wrap shows
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h3C;
    endfunction
    fdr_link_if i_fdr_link_if ();
    fdr_dev_end i_fdr_dev_end (.CLK(clk), .ARST_N(arst_n), .LINK(i_fdr_link_if),
        .WRITE_IN_PROGRESS(wr_busy), .QUAD_ENABLE_BIT(quad_en), .QUAD_COMMAND_MODE(qcm),
        .DUMMY_CLKS(dum), .MEM_ADDR(mem_addr), .MEM_DATA(mem(mem_addr)),
        .CONT_READ_ACTIVE(crm), .READ_REJECTED(rej));
    fdr_host_end i_fdr_host_end (.CLK(clk), .ARST_N(arst_n), .LINK(i_fdr_link_if),
        .START(start), .KIND(kind), .QUAD_COMMAND_MODE(qcm), .QUAD_ENABLE_SET(quad_en),
        .SKIP_OPCODE(skip),
        .START_ADDR(saddr), .MODE_BITS(mode), .DUMMY_CLKS(dum), .BYTE_COUNT(cnt),
        .BUSY(busy), .RD_DATA(rd_data), .RD_VALID(rd_valid), .DONE(done), .ERR(err));
    fdr_link_monitor i_fdr_link_monitor (.CLK(clk), .ARST_N(arst_n),
        .ce_n(i_fdr_link_if.ce_n), .sck(i_fdr_link_if.sck),
        .host_io_oe_n(i_fdr_link_if.host_io_oe_n), .dev_io_o(i_fdr_link_if.dev_io_o),
        .dev_io_oe_n(i_fdr_link_if.dev_io_oe_n));
    task automatic stop_test;
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic ok, input string s);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, s);
        end
    endtask
    // One whole read; a refused flash leaves the pulled-up lanes, so all ones
    task automatic rd(input fdr_kind_t k, input logic q, e, s, input logic [23:0] a,
                      input logic [7:0] m, input logic [4:0] d, input logic [15:0] n,
                      input logic x_err, x_crm);
        logic [23:0] p;
        logic [15:0] got;
        logic        rj;
        logic        er;
        p = a;
        got = 16'h0000;
        rj = 1'b0;
        er = 1'b0;
        @(posedge clk);
        #1;
        kind = k;
        qcm = q;
        quad_en = e;
        skip = s;
        saddr = a;
        mode = m;
        dum = d;
        cnt = n;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        chk(busy === !x_err, "busy flag wrong");
        for (int t = 0; t < 6000; t++) begin
            if (rd_valid === 1'b1) begin
                chk(rd_data === (wr_busy ? 8'hFF : mem(p)), "read byte wrong");
                p = p + 24'h000001;
                got = got + 16'h0001;
            end
            rj = rj | (rej === 1'b1);
            er = er | (err === 1'b1);
            if (done === 1'b1 || err === 1'b1)
                break;
            if (t == 5999) begin
                err_count++;
                $display("BAD %0t read never finished", $time);
                stop_test();
            end
            @(posedge clk);
            #1;
        end
        chk(er === x_err, "refusal flag wrong");
        chk(rj === wr_busy, "write-busy rejection wrong");
        chk(got === (x_err ? 16'h0000 : n), "byte count wrong");
        chk(crm === x_crm, "continuous mode wrong");
    endtask
    task automatic t_single;
        rd(FDR_K_SINGLE, 1'b0, 1'b0, 1'b0, 24'hFFFFFE, 8'h00, 5'h00, 16'h0004, 1'b0, 1'b0);
    endtask
    task automatic t_dual;
        rd(FDR_K_DUAL, 1'b0, 1'b0, 1'b0, 24'h012345, 8'hA5, 5'h00, 16'h0003, 1'b0, 1'b1);
        rd(FDR_K_DUAL, 1'b0, 1'b0, 1'b1, 24'h0ABCDE, 8'h5A, 5'h03, 16'h0002, 1'b0, 1'b0);
    endtask
    task automatic t_quad;
        rd(FDR_K_QUAD, 1'b0, 1'b1, 1'b0, 24'h7FFFFF, 8'hA0, 5'h00, 16'h0002, 1'b0, 1'b1);
        rd(FDR_K_QUAD, 1'b0, 1'b1, 1'b1, 24'h100000, 8'hAF, 5'h07, 16'h0002, 1'b0, 1'b1);
        rd(FDR_K_QUAD, 1'b0, 1'b1, 1'b1, 24'h200010, 8'h00, 5'h00, 16'h0001, 1'b0, 1'b0);
    endtask
    task automatic t_qcm;
        rd(FDR_K_SINGLE, 1'b1, 1'b0, 1'b0, 24'h00FFFF, 8'hA0, 5'h00, 16'h0003, 1'b0, 1'b0);
        rd(FDR_K_QUAD, 1'b1, 1'b0, 1'b0, 24'h800001, 8'h00, 5'h00, 16'h0002, 1'b0, 1'b0);
    endtask
    task automatic t_refuse;
        rd(FDR_K_QUAD, 1'b0, 1'b0, 1'b0, 24'h000000, 8'h00, 5'h00, 16'h0001, 1'b1, 1'b0);
        rd(FDR_K_DUAL, 1'b1, 1'b0, 1'b0, 24'h000000, 8'h00, 5'h00, 16'h0001, 1'b1, 1'b0);
    endtask
    task automatic t_wr_busy;
        wr_busy = 1'b1;
        rd(FDR_K_DUAL, 1'b0, 1'b0, 1'b0, 24'h000010, 8'hA0, 5'h00, 16'h0001, 1'b0, 1'b0);
        wr_busy = 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_single();
        t_dual();
        t_quad();
        t_qcm();
        t_refuse();
        t_wr_busy();
        stop_test();
    end
endmodule // testbench

// ==== verilog/fdr_dev_end.sv ====
// Flash end of the double-rate read link
`timescale 1ns/1ps
module fdr_dev_end
    import fdr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    fdr_link_if.dev          LINK,
    input  wire logic        WRITE_IN_PROGRESS,
    input  wire logic        QUAD_ENABLE_BIT,
    input  wire logic        QUAD_COMMAND_MODE,
    input  wire logic [4:0]  DUMMY_CLKS,
    output logic      [23:0] MEM_ADDR,
    input  wire logic [7:0]  MEM_DATA,
    output logic             CONT_READ_ACTIVE,
    output logic             READ_REJECTED
);

    fdr_dev_regs_t r;
    fdr_dev_regs_t n;

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign LINK.dev_io_o    = r.dout;
    assign LINK.dev_io_oe_n = r.doe_n;
    assign MEM_ADDR         = r.addr;
    assign CONT_READ_ACTIVE = r.crm;
    assign READ_REJECTED    = r.rej;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic        edge_any;
        logic        rise;
        logic [5:0]  cnt1;
        logic [23:0] shv;
        logic [7:0]  lane;
        edge_any = 1'b0;
        rise     = 1'b0;
        cnt1     = 6'h00;
        shv      = 24'h000000;
        lane     = 8'h00;
        n        = r;
        n.ce_m   = LINK.ce_n;
        n.ce_s   = r.ce_m;
        n.sck_m  = LINK.sck;
        n.sck_s  = r.sck_m;
        n.sck_d  = r.sck_s;
        n.io_m   = LINK.io;
        n.io_s   = r.io_m;
        n.rej    = 1'b0;
        edge_any = r.sck_s ^ r.sck_d;
        rise     = r.sck_s & ~r.sck_d;
        cnt1     = r.cnt + 6'h01;
        if (r.ce_s) begin
            // Deselect ends any phase and releases the lanes
            n.st    = DS_IDLE;
            n.doe_n = 4'hF;
            n.dout  = 4'h0;
            if (r.st != DS_IDLE)
                n.crm = r.crm_nxt;
        end else begin
            case (r.st)
                DS_IDLE: begin
                    n.cnt = 6'h00;
                    n.sh  = 8'h00;
                    if (r.crm) begin
                        // Armed: first clocks are address in the armed width
                        n.crm_nxt = r.crm;
                        n.crm_ok  = 1'b1;
                        n.w       = r.crm_w;
                        n.dum     = fdr_dummy(DUMMY_CLKS, r.crm_w);
                        if (WRITE_IN_PROGRESS) begin
                            n.st  = DS_IGNORE;
                            n.rej = 1'b1;
                        end else begin
                            n.st = DS_ADDR;
                        end
                    end else begin
                        n.crm_nxt = 1'b0;
                        n.st      = DS_OPC;
                        n.w       = QUAD_COMMAND_MODE ? FDR_W4 : FDR_W1;
                    end
                end
                DS_OPC: begin
                    if (rise) begin
                        shv  = fdr_shin({16'h0000, r.sh}, r.io_s, r.w);
                        n.sh = shv[7:0];
                        n.cnt = cnt1;
                        if (cnt1 == (`FDR_BYTE_BITS >> r.w)) begin
                            n.cnt = 6'h00;
                            n.st  = DS_IGNORE;
                            if (WRITE_IN_PROGRESS) begin
                                n.rej = 1'b1;
                            end else begin
                                case (shv[7:0])
                                    `FDR_OP_SINGLE: begin
                                        n.st     = DS_ADDR;
                                        n.crm_ok = 1'b0;
                                    end
                                    `FDR_OP_DUAL: begin
                                        if (!QUAD_COMMAND_MODE) begin
                                            n.st     = DS_ADDR;
                                            n.w      = FDR_W2;
                                            n.crm_ok = 1'b1;
                                        end
                                    end
                                    `FDR_OP_QUAD: begin
                                        if (QUAD_COMMAND_MODE || QUAD_ENABLE_BIT) begin
                                            n.st     = DS_ADDR;
                                            n.w      = FDR_W4;
                                            n.crm_ok = 1'b1;
                                        end
                                    end
                                    default: n.st = DS_IGNORE;
                                endcase
                            end
                            n.dum = fdr_dummy(DUMMY_CLKS, n.w);
                        end
                    end
                end
                DS_ADDR: begin
                    // Falling edge closing the opcode carries no address bits
                    if (edge_any && (rise || r.cnt != 6'h00)) begin
                        // Address taken on both edges
                        n.addr = fdr_shin(r.addr, r.io_s, r.w);
                        n.cnt  = cnt1;
                        if (cnt1 == (`FDR_ADDR_BITS >> r.w)) begin
                            n.cnt = 6'h00;
                            n.sh  = 8'h00;
                            n.st  = DS_DUMMY;
                        end
                    end
                end
                DS_DUMMY: begin
                    if (edge_any) begin
                        n.cnt = cnt1;
                        if (r.crm_ok && (r.cnt < (`FDR_NIBBLE_BITS >> r.w))) begin
                            shv  = fdr_shin({16'h0000, r.sh}, r.io_s, r.w);
                            n.sh = shv[7:0];
                            if (cnt1 == (`FDR_NIBBLE_BITS >> r.w)) begin
                                n.crm_nxt = (shv[3:0] == `FDR_CRM_NIBBLE);
                                n.crm_w   = r.w;
                            end
                        end
                        if (cnt1 == {r.dum, 1'b0}) begin
                            n.cnt  = 6'h00;
                            n.st   = DS_DATA;
                            n.sh   = MEM_DATA;
                            n.addr = r.addr + 24'h000001;
                        end
                    end
                end
                DS_DATA: begin
                    if (edge_any) begin
                        // One lane group per edge, next byte fetched on wrap
                        n.sh  = fdr_shl(r.sh, r.w);
                        n.cnt = cnt1;
                        if (cnt1 == (`FDR_BYTE_BITS >> r.w)) begin
                            n.cnt  = 6'h00;
                            n.sh   = MEM_DATA;
                            n.addr = r.addr + 24'h000001;
                        end
                    end
                end
                DS_IGNORE: n.doe_n = 4'hF;
                default:   n.st = DS_IGNORE;
            endcase
            if (n.st == DS_DATA) begin
                lane    = fdr_lane_out(n.sh, n.w, 1'b1);
                n.doe_n = lane[7:4];
                n.dout  = lane[3:0];
            end else begin
                n.doe_n = 4'hF;
                n.dout  = 4'h0;
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r       <= '0;
            r.ce_m  <= 1'b1;
            r.ce_s  <= 1'b1;
            r.doe_n <= 4'hF;
        end else begin
            r <= n;
        end
    end

endmodule // fdr_dev_end

// ==== verilog/fdr_host_end.sv ====
// Host controller end of the double-rate read link
`timescale 1ns/1ps
module fdr_host_end
    import fdr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    fdr_link_if.host         LINK,
    input  wire logic        START,
    input  wire fdr_kind_t   KIND,
    input  wire logic        QUAD_COMMAND_MODE,
    input  wire logic        QUAD_ENABLE_SET,
    input  wire logic        SKIP_OPCODE,
    input  wire logic [23:0] START_ADDR,
    input  wire logic [7:0]  MODE_BITS,
    input  wire logic [4:0]  DUMMY_CLKS,
    input  wire logic [15:0] BYTE_COUNT,
    output logic             BUSY,
    output logic      [7:0]  RD_DATA,
    output logic             RD_VALID,
    output logic             DONE,
    output logic             ERR
);

    fdr_host_regs_t r;
    fdr_host_regs_t n;

    assign LINK.ce_n         = r.ce_n;
    assign LINK.sck          = r.sck;
    assign LINK.host_io_o    = r.dout;
    assign LINK.host_io_oe_n = r.doe_n;
    assign BUSY              = (r.st != HS_IDLE);
    assign RD_DATA           = r.rd_data;
    assign RD_VALID          = r.rd_valid;
    assign DONE              = r.done;
    assign ERR               = r.err;

    // ---------------------------------------------------------------
    // Sequencer, one link edge per half period
    // ---------------------------------------------------------------
    always_comb begin
        logic [5:0]  cnt1;
        logic [7:0]  lane;
        logic [23:0] shv;
        fdr_width_t  dw;
        cnt1       = r.cnt + 6'h01;
        lane       = 8'h00;
        shv        = 24'h000000;
        dw         = FDR_W1;
        n          = r;
        n.io_m     = LINK.io;
        n.io_s     = r.io_m;
        n.rd_valid = 1'b0;
        n.done     = 1'b0;
        n.err      = 1'b0;
        if (r.st == HS_IDLE) begin
            n.ph  = 4'h0;
            n.cnt = 6'h00;
            case (KIND)
                FDR_K_DUAL: dw = FDR_W2;
                FDR_K_QUAD: dw = FDR_W4;
                default:    dw = QUAD_COMMAND_MODE ? FDR_W4 : FDR_W1;
            endcase
            if (START) begin
                if ((KIND == FDR_K_QUAD && !QUAD_COMMAND_MODE && !QUAD_ENABLE_SET)
                    || (KIND == FDR_K_DUAL && QUAD_COMMAND_MODE)
                    || (KIND == FDR_K_SINGLE && SKIP_OPCODE)
                    || (BYTE_COUNT == 16'h0000)) begin
                    n.err = 1'b1;
                end else begin
                    n.ce_n    = 1'b0;
                    n.st      = SKIP_OPCODE ? HS_ADR : HS_OPC;
                    n.dw      = dw;
                    n.w       = SKIP_OPCODE ? dw : (QUAD_COMMAND_MODE ? FDR_W4 : FDR_W1);
                    n.a       = START_ADDR;
                    n.m       = MODE_BITS;
                    n.left    = BYTE_COUNT;
                    n.dum     = fdr_dummy(DUMMY_CLKS, dw);
                    // Quad command single read sends them too; the flash ignores them
                    n.mode_on = (KIND != FDR_K_SINGLE) || QUAD_COMMAND_MODE;
                    case (KIND)
                        FDR_K_DUAL: n.op = `FDR_OP_DUAL;
                        FDR_K_QUAD: n.op = `FDR_OP_QUAD;
                        default:    n.op = `FDR_OP_SINGLE;
                    endcase
                end
            end
        end else begin
            n.ph = r.ph + 4'h1;
            // Lanes change mid half period, away from the clock edge
            if (r.ph == `FDR_SCK_MID) begin
                case (r.st)
                    HS_OPC: begin
                        if (!r.sck) begin
                            lane = fdr_lane_out(r.op, r.w, 1'b0);
                            n.op = fdr_shl(r.op, r.w);
                        end else begin
                            lane = {r.doe_n, r.dout};
                        end
                    end
                    HS_ADR: begin
                        lane = fdr_lane_out(r.a[23:16], r.w, 1'b0);
                        n.a  = r.a << (4'h1 << r.w);
                    end
                    HS_DUM: begin
                        // Only the upper nibble is driven, low nibble left floating
                        if (r.mode_on && (r.cnt < (`FDR_NIBBLE_BITS >> r.w))) begin
                            lane = fdr_lane_out(r.m, r.w, 1'b0);
                            n.m  = fdr_shl(r.m, r.w);
                        end else begin
                            lane = 8'hF0;
                        end
                    end
                    default: lane = 8'hF0;
                endcase
                n.doe_n = lane[7:4];
                n.dout  = lane[3:0];
            end
            if (r.ph == `FDR_SCK_LAST) begin
                n.ph  = 4'h0;
                n.cnt = cnt1;
                if (r.st != HS_END)
                    n.sck = ~r.sck;
                case (r.st)
                    HS_OPC: begin
                        if (cnt1 == (`FDR_BYTE_BITS >> r.w) << 1) begin
                            n.cnt = 6'h00;
                            n.st  = HS_ADR;
                            n.w   = r.dw;
                        end
                    end
                    HS_ADR: begin
                        if (cnt1 == (`FDR_ADDR_BITS >> r.w)) begin
                            n.cnt = 6'h00;
                            n.st  = HS_DUM;
                        end
                    end
                    HS_DUM: begin
                        if (cnt1 == {r.dum, 1'b0}) begin
                            n.cnt   = 6'h00;
                            n.st    = HS_DAT;
                            n.doe_n = 4'hF;
                            n.dout  = 4'h0;
                        end
                    end
                    HS_DAT: begin
                        // Sampled just before the edge that advances the flash
                        // Single lane answers on lane 1, not on lane 0
                        shv  = fdr_shin({16'h0000, r.rx},
                                        (r.w == FDR_W1) ? {3'h0, r.io_s[1]} : r.io_s,
                                        r.w);
                        n.rx = shv[7:0];
                        if (cnt1 == (`FDR_BYTE_BITS >> r.w)) begin
                            n.cnt      = 6'h00;
                            n.rd_data  = shv[7:0];
                            n.rd_valid = 1'b1;
                            n.left     = r.left - 16'h0001;
                            if (r.left == 16'h0001)
                                n.st = HS_END;
                        end
                    end
                    HS_END: begin
                        if (r.cnt == 6'h00) begin
                            n.ce_n = 1'b1;
                        end else begin
                            n.st   = HS_IDLE;
                            n.done = 1'b1;
                        end
                    end
                    default: n.st = HS_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r       <= '0;
            r.ce_n  <= 1'b1;
            r.doe_n <= 4'hF;
        end else begin
            r <= n;
        end
    end

endmodule // fdr_host_end

// ==== verilog/fdr_link_if.sv ====
// Serial link between host controller and flash read engine
`timescale 1ns/1ps
interface fdr_link_if;
    logic       ce_n;
    logic       sck;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe_n;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe_n;
    logic [3:0] io;

    // Undriven lanes float to a pulled-up one
    assign io = (~dev_io_oe_n & dev_io_o)
              | (dev_io_oe_n & ~host_io_oe_n & host_io_o)
              | (dev_io_oe_n & host_io_oe_n);

    modport dev  (input ce_n, sck, io, output dev_io_o, dev_io_oe_n);
    modport host (output ce_n, sck, host_io_o, host_io_oe_n, input io);
endinterface // fdr_link_if

// ==== verilog/fdr_pkg.sv ====
// Types and helpers shared by both ends of the read link
package fdr_pkg;
`include "fdr_regs.svh"

    typedef enum logic [1:0] {
        FDR_W1 = 2'h0,
        FDR_W2 = 2'h1,
        FDR_W4 = 2'h2
    } fdr_width_t;

    typedef enum logic [1:0] {
        FDR_K_SINGLE = 2'h0,
        FDR_K_DUAL   = 2'h1,
        FDR_K_QUAD   = 2'h2
    } fdr_kind_t;

    typedef enum logic [2:0] {
        DS_IDLE   = 3'h0,
        DS_OPC    = 3'h1,
        DS_ADDR   = 3'h2,
        DS_DUMMY  = 3'h3,
        DS_DATA   = 3'h4,
        DS_IGNORE = 3'h5
    } fdr_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_OPC  = 3'h1,
        HS_ADR  = 3'h2,
        HS_DUM  = 3'h3,
        HS_DAT  = 3'h4,
        HS_END  = 3'h5
    } fdr_host_state_t;

    typedef struct packed {
        logic            ce_m, ce_s, sck_m, sck_s, sck_d;
        logic [3:0]      io_m, io_s;
        fdr_dev_state_t  st;
        fdr_width_t      w, crm_w;
        logic [5:0]      cnt;
        logic [4:0]      dum;
        logic [7:0]      sh;
        logic [23:0]     addr;
        logic            crm, crm_nxt, crm_ok, rej;
        logic [3:0]      dout, doe_n;
    } fdr_dev_regs_t;

    typedef struct packed {
        logic            ce_n, sck;
        logic [3:0]      dout, doe_n, io_m, io_s;
        fdr_host_state_t st;
        fdr_width_t      w, dw;
        logic [3:0]      ph;
        logic [5:0]      cnt;
        logic [7:0]      op, m, rx, rd_data;
        logic [23:0]     a;
        logic [4:0]      dum;
        logic [15:0]     left;
        logic            mode_on, rd_valid, done, err;
    } fdr_host_regs_t;

    // Shift lane bits in at the bottom, MSB first
    function automatic logic [23:0] fdr_shin(input logic [23:0] v, input logic [3:0] io,
                                             input fdr_width_t w);
        case (w)
            FDR_W2:  return {v[21:0], io[1:0]};
            FDR_W4:  return {v[19:0], io};
            default: return {v[22:0], io[0]};
        endcase
    endfunction

    // {oe_n, out} for the top lane bits; single lane is io0 in, io1 out
    function automatic logic [7:0] fdr_lane_out(input logic [7:0] v, input fdr_width_t w,
                                                input logic to_host);
        case (w)
            FDR_W2:  return {4'hC, 2'h0, v[7:6]};
            FDR_W4:  return {4'h0, v[7:4]};
            default: return to_host ? {4'hD, 2'h0, v[7], 1'h0} : {4'hE, 3'h0, v[7]};
        endcase
    endfunction

    function automatic logic [7:0] fdr_shl(input logic [7:0] v, input fdr_width_t w);
        return v << (4'h1 << w);
    endfunction

    function automatic logic [4:0] fdr_dummy(input logic [4:0] cfg, input fdr_width_t w);
        if (cfg != 5'h00)
            return cfg;
        case (w)
            FDR_W2:  return `FDR_DUMMY_DUAL;
            FDR_W4:  return `FDR_DUMMY_QUAD;
            default: return `FDR_DUMMY_SINGLE;
        endcase
    endfunction
endpackage

// ==== verilog/fdr_regs.svh ====
// Constants of the double-rate flash read engine
`ifndef FDR_REGS_SVH
`define FDR_REGS_SVH
// Notes on behaviour
// - Address and data move on both clock edges
// - Single-line read: opcode, address, dummy, data
// - Any start address, increments, wraps to zero
// - Chip enable high ends read, outputs released
// - Write in progress rejects every read
// - Quad command single-line read uses four lanes
// - No continuous mode for quad-command single read
// - Dual read: two lanes, four dummy default
// - Mode nibble A arms dual continuous mode
// - Host sets quad enable before quad read
// - Quad read: four lanes, six dummy default
// - Quad command quad read ignores quad enable
// - Mode nibble A arms quad continuous mode
// - Other nibble leaves continuous mode after read
// - Host releases ignored nibble, enough dummy clocks
// - Host picks dummy count for its clock

// ---------------------------------------------------------------
// Opcodes and mode bits
// ---------------------------------------------------------------
`define FDR_OP_SINGLE      8'h0D
`define FDR_OP_DUAL        8'hBD
`define FDR_OP_QUAD        8'hED
`define FDR_CRM_NIBBLE     4'hA

// ---------------------------------------------------------------
// Default dummy clocks per lane width
// ---------------------------------------------------------------
`define FDR_DUMMY_SINGLE   5'h08
`define FDR_DUMMY_DUAL     5'h04
`define FDR_DUMMY_QUAD     5'h06

// ---------------------------------------------------------------
// Bit counts of each phase, edges = bits >> lane code; opcode rising edges = bits >> lane code
// ---------------------------------------------------------------
`define FDR_ADDR_BITS      6'h18
`define FDR_BYTE_BITS      6'h08
`define FDR_NIBBLE_BITS    6'h04

// ---------------------------------------------------------------
// Host serial clock divider, CLK cycles per half period
// ---------------------------------------------------------------
`define FDR_SCK_MID        4'h3
`define FDR_SCK_LAST       4'h7
`endif
